// [qbio_board.sv]
// board model: undriven pins show the bench's board levels
// assumes the block drives a pin only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module qbio_board
	import qbio_pkg::*;
(
	// from the block and the bench
	input wire qbio_pad_t pad,
	input wire qbio_quad_t board,
	// to the block
	output wire qbio_quad_t pad_in
);
	assign pad_in = (pad.lvl & pad.oe) | (board & ~pad.oe);
endmodule
`default_nettype wire

// [qbio_pkg.sv]
// types shared by the quad byte port block
// no assumptions beyond the register header
`default_nettype none
package qbio_pkg;
	typedef logic [7:0] qbio_byte_t;
	typedef logic [3:0][7:0] qbio_quad_t;

	// pad side of all four ports, index 0 is port one
	typedef struct packed {
		qbio_quad_t lvl;
		qbio_quad_t oe;
	} qbio_pad_t;

	// signals and enables owned by neighbouring units
	typedef struct packed {
		logic [2:0] first_timer_src;
		logic [2:0] second_timer_src;
		logic modulator_en;
		logic first_modulator_out;
		logic second_modulator_out;
		logic expansion_write_en;
		logic expansion_write_strobe_n;
		logic two_flash_en;
		logic second_flash_select_n;
		logic low_voltage_en;
		logic low_voltage_flag_n;
		logic mem_decoder_en;
		logic serial_en;
		logic serial_tx;
		logic display_en;
	} qbio_alt_t;

	// cpu memory cycle seen by the decoders
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
	} qbio_cpu_t;
endpackage
`default_nettype wire

// [qbio_regs.svh]
// register offsets, field positions, reset values and timing counts of the port block
// assumes a 16-bit byte address on the register port and 8-bit data
`ifndef QBIO_REGS_SVH
`define QBIO_REGS_SVH

`define QBIO_ADDR_P1_DATA 16'h1020
`define QBIO_ADDR_P1_DIR 16'h1021
`define QBIO_ADDR_P1_FLAGS 16'h1022
`define QBIO_ADDR_P1_KIND 16'h1023
`define QBIO_ADDR_P2_DATA 16'h1024
`define QBIO_ADDR_P2_DIR 16'h1025
`define QBIO_ADDR_P2_FLAGS 16'h1026
`define QBIO_ADDR_P2_KIND 16'h1027
`define QBIO_ADDR_P3_DATA 16'h1028
`define QBIO_ADDR_P3_DIR 16'h1029
`define QBIO_ADDR_P3_FLAGS 16'h102a
`define QBIO_ADDR_PULLUP 16'h102b
`define QBIO_ADDR_DRIVE 16'h102c
`define QBIO_ADDR_IN_CTRL 16'h102d
`define QBIO_ADDR_P4_DATA 16'h1040
`define QBIO_ADDR_P4_DIR 16'h1041
`define QBIO_MEM_LO 16'h4000
`define QBIO_MEM_HI 16'h7fff
`define QBIO_DISP_ADDR_A 16'h100e
`define QBIO_DISP_ADDR_B 16'h100f
`define QBIO_RESET_BYTE 8'h00
`define QBIO_TIMER_SRC_PIN 3'h0
`define QBIO_CTRL_FILTER_LSB 4
`define QBIO_CTRL_IRQEN_LSB 0
`define QBIO_DEBOUNCE_NS 400
`define QBIO_CLK_NS 100

`endif

// [qbio_top.sv]
// four 8-bit general purpose ports with alternate pin functions
// assumes pad levels arrive asynchronously; neighbour units share clk
`timescale 1ns/1ps
`default_nettype none
`include "qbio_regs.svh"

module qbio_top
	import qbio_pkg::*;
#(
	parameter int DEBOUNCE_NS = `QBIO_DEBOUNCE_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// pads
	input wire qbio_quad_t pad_in,
	output qbio_pad_t pad,
	output logic [7:0] pullup_en,
	output logic [7:0] drive_high,
	// neighbouring units
	input wire qbio_alt_t alt,
	input wire qbio_cpu_t cpu,
	output logic first_timer_clk,
	output logic second_timer_clk,
	output logic serial_rx
);

	localparam int DEB_CYCLES_RAW = (DEBOUNCE_NS + `QBIO_CLK_NS - 1) / `QBIO_CLK_NS;
	localparam int DEB_CYCLES = (DEB_CYCLES_RAW < 1) ? 1 : DEB_CYCLES_RAW;
	localparam int DW = $clog2(DEB_CYCLES + 1);

	// ****************************************
	// registers
	// ****************************************
	qbio_quad_t data_q;
	qbio_quad_t dir_q;
	logic [2:0][7:0] flags_q;
	logic [1:0][7:0] kind_q;
	qbio_byte_t pullup_q;
	qbio_byte_t drive_q;
	qbio_byte_t in_ctrl_q;
	qbio_quad_t sync1_q;
	qbio_quad_t sync2_q;
	qbio_quad_t in_lvl;
	qbio_quad_t prev_q;
	logic [2:0][7:0] trig;
	logic [1:0][7:0] wr_flags;
	logic [7:0] wr_flags3;
	logic mem_hit;
	logic disp_hit;
	logic disp_rw_q;

	assign mem_hit = (cpu.addr >= `QBIO_MEM_LO) && (cpu.addr <= `QBIO_MEM_HI);
	assign disp_hit = (cpu.addr == `QBIO_DISP_ADDR_A) || (cpu.addr == `QBIO_DISP_ADDR_B);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_q <= '0;
			dir_q <= '0;
			kind_q <= '0;
			pullup_q <= `QBIO_RESET_BYTE;
			drive_q <= `QBIO_RESET_BYTE;
			in_ctrl_q <= `QBIO_RESET_BYTE;
		end else if (reg_wr) begin
			if (reg_addr == `QBIO_ADDR_P1_DATA) begin
				data_q[0] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P2_DATA) begin
				data_q[1] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P3_DATA) begin
				data_q[2] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P4_DATA) begin
				data_q[3] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P1_DIR) begin
				dir_q[0] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P2_DIR) begin
				dir_q[1] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P3_DIR) begin
				dir_q[2] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P4_DIR) begin
				dir_q[3] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P1_KIND) begin
				kind_q[0] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_P2_KIND) begin
				kind_q[1] <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_PULLUP) begin
				pullup_q <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_DRIVE) begin
				drive_q <= reg_wdata;
			end else if (reg_addr == `QBIO_ADDR_IN_CTRL) begin
				in_ctrl_q <= reg_wdata;
			end
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// output bits read back the register, input bits the conditioned pad
	function automatic qbio_byte_t port_view(qbio_byte_t d, qbio_byte_t dr, qbio_byte_t lv);
		port_view = (d & dr) | (lv & ~dr);
	endfunction

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (reg_addr == `QBIO_ADDR_P1_DATA) begin
			reg_rdata <= port_view(data_q[0], dir_q[0], in_lvl[0]);
		end else if (reg_addr == `QBIO_ADDR_P2_DATA) begin
			reg_rdata <= port_view(data_q[1], dir_q[1], in_lvl[1]);
		end else if (reg_addr == `QBIO_ADDR_P3_DATA) begin
			reg_rdata <= port_view(data_q[2], dir_q[2], in_lvl[2]);
		end else if (reg_addr == `QBIO_ADDR_P4_DATA) begin
			reg_rdata <= port_view(data_q[3], dir_q[3], in_lvl[3]);
		end else if (reg_addr == `QBIO_ADDR_P1_DIR) begin
			reg_rdata <= dir_q[0];
		end else if (reg_addr == `QBIO_ADDR_P2_DIR) begin
			reg_rdata <= dir_q[1];
		end else if (reg_addr == `QBIO_ADDR_P3_DIR) begin
			reg_rdata <= dir_q[2];
		end else if (reg_addr == `QBIO_ADDR_P4_DIR) begin
			reg_rdata <= dir_q[3];
		end else if (reg_addr == `QBIO_ADDR_P1_FLAGS) begin
			reg_rdata <= flags_q[0];
		end else if (reg_addr == `QBIO_ADDR_P2_FLAGS) begin
			reg_rdata <= flags_q[1];
		end else if (reg_addr == `QBIO_ADDR_P3_FLAGS) begin
			reg_rdata <= flags_q[2];
		end else if (reg_addr == `QBIO_ADDR_P1_KIND) begin
			reg_rdata <= kind_q[0];
		end else if (reg_addr == `QBIO_ADDR_P2_KIND) begin
			reg_rdata <= kind_q[1];
		end else if (reg_addr == `QBIO_ADDR_PULLUP) begin
			reg_rdata <= pullup_q;
		end else if (reg_addr == `QBIO_ADDR_DRIVE) begin
			reg_rdata <= drive_q;
		end else if (reg_addr == `QBIO_ADDR_IN_CTRL) begin
			reg_rdata <= in_ctrl_q;
		end else begin
			reg_rdata <= '0;
		end
	end

	// ****************************************
	// input conditioning
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pad_in;
			sync2_q <= sync1_q;
		end
	end

	// ports one and two get a per-pin filter; a pin follows only after
	// it held a new level for the whole debounce time
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_in
			if (g < 16) begin : g_deb
				logic stable_q;
				logic [DW-1:0] cnt_q;
				always_ff @(posedge clk or negedge rstn) begin
					if (!rstn) begin
						stable_q <= 1'b0;
						cnt_q <= '0;
					end else if (sync2_q[g/8][g%8] == stable_q) begin
						cnt_q <= '0;
					end else if (cnt_q >= DW'(DEB_CYCLES - 1)) begin
						stable_q <= sync2_q[g/8][g%8];
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				// select bits 7..4 cover port two high..port one low nibble
				assign in_lvl[g/8][g%8] = in_ctrl_q[`QBIO_CTRL_FILTER_LSB + g/4] ?
					stable_q : sync2_q[g/8][g%8];
			end else begin : g_raw
				assign in_lvl[g/8][g%8] = sync2_q[g/8][g%8];
			end
		end
	endgenerate

	// ****************************************
	// interrupt indicate flags
	// ****************************************
	// ports one/two: rising edge, gated per nibble by the control enables;
	// port three: upper nibble and bits 1,0 rising, bits 3,2 falling
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 8; b++) begin
				trig[p][b] = in_lvl[p][b] & ~prev_q[p][b] &
					in_ctrl_q[`QBIO_CTRL_IRQEN_LSB + p*2 + b/4];
			end
		end
		trig[2] = (in_lvl[2] & ~prev_q[2] & 8'hf3) | (~in_lvl[2] & prev_q[2] & 8'h0c);
	end

	always_comb begin
		wr_flags[0] = (reg_wr && reg_addr == `QBIO_ADDR_P1_FLAGS) ? reg_wdata : 8'hff;
		wr_flags[1] = (reg_wr && reg_addr == `QBIO_ADDR_P2_FLAGS) ? reg_wdata : 8'hff;
		wr_flags3 = (reg_wr && reg_addr == `QBIO_ADDR_P3_FLAGS) ? reg_wdata : 8'hff;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= '0;
			flags_q <= '0;
		end else begin
			prev_q <= in_lvl;
			// a new trigger wins over a clearing write in the same cycle
			flags_q[0] <= (flags_q[0] & wr_flags[0]) | trig[0];
			flags_q[1] <= (flags_q[1] & wr_flags[1]) | trig[1];
			flags_q[2] <= (flags_q[2] & wr_flags3) | trig[2];
		end
	end

	// ****************************************
	// pad drive and alternate functions
	// ****************************************
	qbio_quad_t lvl_d;
	qbio_quad_t oe_d;

	always_comb begin
		for (int p = 0; p < 4; p++) begin
			lvl_d[p] = data_q[p];
			oe_d[p] = dir_q[p];
		end
		// open drain: direction bit is the level, high is released
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (kind_q[p][b]) begin
					lvl_d[p][b] = 1'b0;
					oe_d[p][b] = ~dir_q[p][b];
				end
			end
		end
		if (alt.modulator_en) begin
			lvl_d[1][7] = alt.first_modulator_out;
			lvl_d[1][6] = alt.second_modulator_out;
			oe_d[1][7:6] = 2'h3;
		end
		if (alt.expansion_write_en) begin
			lvl_d[1][5] = alt.expansion_write_strobe_n;
			oe_d[1][5] = 1'b1;
		end
		if (alt.two_flash_en) begin
			lvl_d[1][4] = alt.second_flash_select_n;
			oe_d[1][4] = 1'b1;
		end
		if (alt.low_voltage_en) begin
			lvl_d[1][3] = alt.low_voltage_flag_n;
			oe_d[1][3] = 1'b1;
		end
		if (alt.mem_decoder_en) begin
			lvl_d[1][2] = ~(mem_hit & cpu.wr);
			lvl_d[1][1] = ~(mem_hit & cpu.rd);
			lvl_d[1][0] = ~(mem_hit & (cpu.wr | cpu.rd));
			oe_d[1][2:0] = 3'h7;
		end
		if (alt.serial_en) begin
			lvl_d[2][3] = alt.serial_tx;
			oe_d[2][3] = 1'b1;
			lvl_d[2][2] = 1'b0;
			oe_d[2][2] = 1'b0;
		end
		if (alt.display_en) begin
			lvl_d[2][1] = disp_hit & (cpu.wr | cpu.rd);
			// rw must already be valid while the enable strobe stands
			lvl_d[2][0] = (disp_hit && (cpu.wr || cpu.rd)) ? cpu.rd : disp_rw_q;
			oe_d[2][1:0] = 2'h3;
		end
	end

	// read/write line holds the kind of the last display access
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			disp_rw_q <= 1'b0;
		end else if (disp_hit && (cpu.wr || cpu.rd)) begin
			disp_rw_q <= cpu.rd;
		end
	end

	// registered pads cost one cycle on every strobe; accepted so that
	// no pad ever glitches from decode logic
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pad <= '0;
			pullup_en <= '0;
			drive_high <= '0;
			first_timer_clk <= 1'b0;
			second_timer_clk <= 1'b0;
			serial_rx <= 1'b1;
		end else begin
			pad.lvl <= lvl_d;
			pad.oe <= oe_d;
			pullup_en <= pullup_q;
			drive_high <= drive_q;
			first_timer_clk <= (alt.first_timer_src == `QBIO_TIMER_SRC_PIN) &
				in_lvl[0][0];
			second_timer_clk <= (alt.second_timer_src == `QBIO_TIMER_SRC_PIN) &
				in_lvl[0][1];
			serial_rx <= alt.serial_en ? in_lvl[2][2] : 1'b1;
		end
	end

endmodule

`default_nettype wire

// [qbio_top_sva.sv]
// assertions on the ports of the quad byte port block
// assumes one clock, outputs registered one cycle after their cause
`timescale 1ns/1ps
`default_nettype none
module qbio_top_sva
	import qbio_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// pads and neighbours
	input wire qbio_quad_t pad_in,
	input wire qbio_pad_t pad,
	input wire logic [7:0] pullup_en,
	input wire logic [7:0] drive_high,
	input wire qbio_alt_t alt,
	input wire qbio_cpu_t cpu,
	input wire logic first_timer_clk,
	input wire logic second_timer_clk,
	input wire logic serial_rx
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_pwm; alt.modulator_en |=> pad.oe[1][7:6] == 2'b11 && pad.lvl[1][7:6]
		== $past({alt.first_modulator_out, alt.second_modulator_out}); endproperty
	a_pwm: assert property (p_pwm) else $error("modulator pins");
	property p_exp; alt.expansion_write_en |=> pad.oe[1][5]
		&& pad.lvl[1][5] == $past(alt.expansion_write_strobe_n); endproperty
	a_exp: assert property (p_exp) else $error("expansion strobe pin");
	property p_lv; alt.low_voltage_en |=> pad.oe[1][3]
		&& pad.lvl[1][3] == $past(alt.low_voltage_flag_n); endproperty
	a_lv: assert property (p_lv) else $error("low voltage pin");
	// only the 4000..7fff window may pull the select low
	property p_mem; alt.mem_decoder_en |=> pad.oe[1][0] && pad.lvl[1][0]
		== !($past(cpu.wr | cpu.rd) && $past(cpu.addr[15:14]) == 2'b01); endproperty
	a_mem: assert property (p_mem) else $error("memory select");
	property p_t1; alt.first_timer_src != 3'h0 |=> !first_timer_clk; endproperty
	a_t1: assert property (p_t1) else $error("first timer clock");
	property p_t2; alt.second_timer_src != 3'h0 |=> !second_timer_clk; endproperty
	a_t2: assert property (p_t2) else $error("second timer clock");
	property p_rx; !alt.serial_en |=> serial_rx; endproperty
	a_rx: assert property (p_rx) else $error("serial input idle");
	property p_pu; reg_wr && reg_addr == 16'h102b |-> ##2 pullup_en == $past(reg_wdata, 2);
	endproperty
	a_pu: assert property (p_pu) else $error("pull-up copy");
	c_pwm: cover property (alt.modulator_en);
	c_mem: cover property (alt.mem_decoder_en && cpu.wr);
	c_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
`default_nettype wire

// [tb_qbio_top.sv]
// self-checking bench for the quad byte port block
// assumes the board model beside the block and the checker bound below
`timescale 1ns/1ps
`default_nettype none
module tb_qbio_top;
	import qbio_pkg::*;
	logic clk, rstn, reg_wr, reg_rd, tclk1, tclk2, rx;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pullup_en, drive_high;
	qbio_quad_t pad_in, board;
	qbio_pad_t pad;
	qbio_alt_t alt;
	qbio_cpu_t cpu;
	int fail_count, checked;
	qbio_top #(.DEBOUNCE_NS(400)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pad_in(pad_in), .pad(pad), .pullup_en(pullup_en), .drive_high(drive_high),
		.alt(alt), .cpu(cpu), .first_timer_clk(tclk1), .second_timer_clk(tclk2),
		.serial_rx(rx));
	qbio_board board_i (.pad(pad), .board(board), .pad_in(pad_in));
	// ****
	// bus and compare tasks
	// ****
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// observe at the falling edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(n, e, reg_rdata);
	endtask
	task automatic pin(input int p, input int b, input logic v);
		@(posedge clk);
		board[p][b] <= v;
	endtask
	// two-cycle pulse: shorter than the four-cycle filter
	task automatic glitch();
		pin(0, 1, 1'b1);
		pin(0, 1, 1'b1);
		pin(0, 1, 1'b0);
		cyc(6);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		for (int a = 'h1020; a <= 'h102c; a++) begin
			rd(16'(a), 8'h00, "reset");
		end
		wr(16'h102b, 8'h81);
		wr(16'h102c, 8'h42);
		wr(16'h1022, 8'hff);
		wr(16'h1030, 8'hff);
		chk("pullup", 8'h81, pullup_en);
		chk("drive", 8'h42, drive_high);
		rd(16'h1022, 8'h00, "flag write");
		rd(16'h1030, 8'h00, "unmapped");
	endtask
	task automatic t_ports();
		wr(16'h1021, 8'hf0);
		wr(16'h1020, 8'ha5);
		@(posedge clk);
		board[0] <= 8'h3c;
		cyc(4);
		chk("p1 enable", 8'hf0, pad.oe[0]);
		rd(16'h1020, 8'hac, "p1 read");
		wr(16'h1023, 8'hff);
		cyc(1);
		chk("drain enable", 8'h0f, pad.oe[0]);
		chk("drain level", 8'h00, pad.lvl[0]);
		wr(16'h1023, 8'h00);
		wr(16'h1021, 8'h00);
		wr(16'h1041, 8'hff);
		wr(16'h1040, 8'h5a);
		cyc(1);
		chk("p4 level", 8'h5a, pad.lvl[3]);
	endtask
	task automatic t_flags();
		wr(16'h102d, 8'h0f);
		pin(0, 0, 1'b1);
		pin(2, 2, 1'b1);
		pin(2, 2, 1'b0);
		cyc(5);
		rd(16'h1022, 8'h01, "p1 flags");
		rd(16'h102a, 8'h04, "p3 flags");
		wr(16'h1022, 8'hfe);
		rd(16'h1022, 8'h00, "cleared");
		wr(16'h102d, 8'h1f);
		cyc(6);
		wr(16'h1022, 8'h00);
		glitch();
		rd(16'h1022, 8'h00, "filtered");
		wr(16'h102d, 8'h0f);
		glitch();
		rd(16'h1022, 8'h02, "unfiltered");
	endtask
	task automatic t_alt();
		logic [15:0] ma [4] = '{16'h3fff, 16'h4000, 16'h7fff, 16'h8000};
		logic miss;
		pin(0, 1, 1'b1);
		alt <= '{first_timer_src: 3'h1, modulator_en: 1'b1, first_modulator_out: 1'b1,
			expansion_write_en: 1'b1, low_voltage_en: 1'b1, mem_decoder_en: 1'b1, two_flash_en: 1'b1,
			serial_en: 1'b1, serial_tx: 1'b1, default: 1'b0};
		cpu.wr <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			cpu.addr <= ma[i];
			cyc(1);
			// outside the window all three strobes stay high; inside only oe_n does
			miss = (i == 0 || i == 3);
			chk("mem pins", {5'h0, miss, 1'b1, miss}, 8'(pad.lvl[1][2:0]));
		end
		chk("pwm pins", 8'h80, {pad.lvl[1][7:6], 6'h0});
		chk("flash select", 8'h02, 8'({pad.oe[1][4], pad.lvl[1][4]}));
		chk("serial in", 8'h00, 8'(rx));
		chk("timer two", 8'h01, 8'(tclk2));
		@(posedge clk);
		alt.display_en <= 1'b1;
		alt.second_timer_src <= 3'h5;
		alt.first_timer_src <= 3'h0;
		cpu.addr <= 16'h100e;
		cyc(1);
		chk("display pins", 8'h02, 8'(pad.lvl[2][1:0]));
		chk("timer one", 8'h01, 8'(tclk1));
		chk("timer two off", 8'h00, 8'(tclk2));
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#5000000;
		fail_count++;
		end_of_test();
	end
	initial begin
		rstn = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		board = '0;
		alt = '0;
		cpu = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_ports();
		t_flags();
		t_alt();
		end_of_test();
	end
endmodule
bind qbio_top qbio_top_sva sva_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pad_in(pad_in), .pad(pad), .pullup_en(pullup_en), .drive_high(drive_high),
	.alt(alt), .cpu(cpu), .first_timer_clk(first_timer_clk),
	.second_timer_clk(second_timer_clk), .serial_rx(serial_rx));
`default_nettype wire
